/* File: hw/pif_flag_cell.sv */
// one sticky interrupt flag, hardware set over software clear
`timescale 1ns/1ps
`default_nettype none
module pif_flag_cell
	import pif_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control
	input wire logic setEvent,
	input wire logic clearReq,
	// state
	output logic flag
);

	logic flag_q;
	logic flag_d;

	// set wins when both land in one cycle
	always_comb begin
		flag_d = flag_q;
		if (clearReq) begin
			flag_d = 1'b0;
		end
		if (setEvent) begin
			flag_d = 1'b1; // RL12
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;

endmodule : pif_flag_cell
`default_nettype wire

/* File: hw/pif_irq_flags.sv */
// peripheral interrupt flag registers behind an ahb-lite slave
// ----------------------------------------------------------------
// Notes on behaviour
// RL1: the clock-switch flag sets when the clock switch unit can finish a switch, held until cleared.
// RL2: the adc threshold flag at bit 1 sets when an adc operation finishes, held until cleared.
// RL3: the adc done flag at bit 0 sets when an adc operation finishes, held until cleared.
// RL4: every flag sets on its condition regardless of any enable or mask.
// RL5: the analog event register holds zero-cross at bit 6 and comparators at bits 1 and 0, reset 0.
// RL6: the zero-cross flag sets on an enabled zero-cross edge event, held until cleared.
// RL7: comparator one sets bit 0 and comparator two sets bit 1, held until cleared.
// RL8: the serial register has read-only rx and tx at bits 5 and 4 and four sticky bits below.
// RL9: the rx flag is high while the receive buffer is not empty and ignores writes.
// RL10: the tx flag is high while the transmit buffer has room and ignores writes.
// RL11: sync port flags set on transfer done, bus collision flags on a collision, held until cleared.
// RL12: a set in the same cycle as a software clear wins, so no event is lost.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pif_irq_flags
	import pif_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// peripheral event strobes
	input wire logic clockSwitchReady,
	input wire logic adcOpDone,
	input wire logic zeroCrossEvent,
	input wire logic [1:0] comparatorIrq,
	input wire logic [1:0] syncPortDone,
	input wire logic [1:0] busCollision,
	// peripheral buffer levels
	input wire logic serialRxNotEmpty,
	input wire logic serialTxHasRoom,
	// interrupt
	output logic irqOut
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// returns {mask selects, flag selects}, one-hot or zero
	function automatic logic [5:0] decodeSel(input logic [ADDR_WIDTH-1:0] addr);
		logic [11:0] idx;
		logic [5:0] sel;
		idx = addr[ADDR_WIDTH-1:2];
		sel = 6'b00_0000;
		if (addr[1:0] == 2'b00) begin
			sel[SLOT_CLOCK_ADC] = (idx == IDX_FLAGS_CLOCK_ADC);
			sel[SLOT_ANALOG] = (idx == IDX_FLAGS_ANALOG);
			sel[SLOT_SERIAL] = (idx == IDX_FLAGS_SERIAL);
			sel[REG_COUNT + SLOT_CLOCK_ADC] = (idx == IDX_MASK_CLOCK_ADC);
			sel[REG_COUNT + SLOT_ANALOG] = (idx == IDX_MASK_ANALOG);
			sel[REG_COUNT + SLOT_SERIAL] = (idx == IDX_MASK_SERIAL);
		end
		return sel;
	endfunction : decodeSel

	// ----------------------------------------------------------------
	// bus phases
	// ----------------------------------------------------------------
	logic addrValid;
	logic inRange;
	logic wrPend_q;
	logic rdPend_q;
	logic [5:0] phaseSel_q;
	logic [5:0] addrSel;

	assign inRange = (haddr[31:ADDR_WIDTH] == '0);
	assign addrValid = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
	assign addrSel = inRange ? decodeSel(haddr[ADDR_WIDTH-1:0]) : 6'b00_0000;

	// zero-wait slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			phaseSel_q <= 6'b00_0000;
		end else if (hready) begin
			wrPend_q <= addrValid && hwrite;
			rdPend_q <= addrValid && !hwrite;
			phaseSel_q <= addrValid ? addrSel : 6'b00_0000;
		end
	end

	// ----------------------------------------------------------------
	// flag and mask storage
	// ----------------------------------------------------------------
	localparam logic [7:0] STICKY [REG_COUNT] = '{STICKY_CLOCK_ADC, STICKY_ANALOG, STICKY_SERIAL};
	localparam logic [7:0] LEVELS [REG_COUNT] = '{8'h00, 8'h00, LEVEL_SERIAL};

	logic [7:0] setVec [REG_COUNT];
	logic [7:0] levelVec [REG_COUNT];
	logic [7:0] flagVec [REG_COUNT];
	logic [7:0] mask_q [REG_COUNT];

	// raw conditions, never gated by mask or enable
	always_comb begin
		setVec[SLOT_CLOCK_ADC] = 8'h00;
		setVec[SLOT_ANALOG] = 8'h00;
		setVec[SLOT_SERIAL] = 8'h00;
		setVec[SLOT_CLOCK_ADC][BIT_CLOCK_SWITCH] = clockSwitchReady; // RL1 RL4
		setVec[SLOT_CLOCK_ADC][BIT_ADC_THRESHOLD] = adcOpDone; // RL2
		setVec[SLOT_CLOCK_ADC][BIT_ADC_DONE] = adcOpDone; // RL3
		setVec[SLOT_ANALOG][BIT_ZERO_CROSS] = zeroCrossEvent; // RL6
		setVec[SLOT_ANALOG][BIT_CMP_ONE] = comparatorIrq[0]; // RL7
		setVec[SLOT_ANALOG][BIT_CMP_TWO] = comparatorIrq[1]; // RL7
		setVec[SLOT_SERIAL][BIT_SYNC_ONE] = syncPortDone[0]; // RL11
		setVec[SLOT_SERIAL][BIT_SYNC_TWO] = syncPortDone[1]; // RL11
		setVec[SLOT_SERIAL][BIT_BUS_COLL_ONE] = busCollision[0]; // RL11
		setVec[SLOT_SERIAL][BIT_BUS_COLL_TWO] = busCollision[1]; // RL11
		levelVec[SLOT_CLOCK_ADC] = 8'h00;
		levelVec[SLOT_ANALOG] = 8'h00;
		levelVec[SLOT_SERIAL] = 8'h00;
		levelVec[SLOT_SERIAL][BIT_SERIAL_RX] = serialRxNotEmpty; // RL9
		levelVec[SLOT_SERIAL][BIT_SERIAL_TX] = serialTxHasRoom; // RL10
	end

	genvar r;
	genvar b;
	generate
		for (r = 0; r < REG_COUNT; r++) begin : gRegs
			logic [7:0] clearVec;
			// write one to clear, data phase
			assign clearVec = (wrPend_q && phaseSel_q[r]) ? hwdata[7:0] : 8'h00;

			for (b = 0; b < REG_WIDTH; b++) begin : gBits
				if (STICKY[r][b]) begin : gSticky
					pif_flag_cell uCell (
						.clk_sys(clk_sys),
						.reset(reset),
						.setEvent(setVec[r][b]),
						.clearReq(clearVec[b]),
						.flag(flagVec[r][b])
					); // RL5 RL8 RL12
				end else if (LEVELS[r][b]) begin : gLevel
					logic level_q;
					// follows the buffer, writes have no effect
					always_ff @(posedge clk_sys or posedge reset) begin
						if (reset) begin
							level_q <= 1'b0;
						end else begin
							level_q <= levelVec[r][b]; // RL9 RL10
						end
					end
					assign flagVec[r][b] = level_q;
				end else begin : gUnused
					assign flagVec[r][b] = 1'b0;
				end
			end

			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					mask_q[r] <= MASK_RESET;
				end else if (wrPend_q && phaseSel_q[REG_COUNT + r]) begin
					mask_q[r] <= hwdata[7:0] & (STICKY[r] | LEVELS[r]);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read data and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		hrdata = READ_ZERO;
		if (rdPend_q) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				if (phaseSel_q[i]) begin
					hrdata[7:0] = flagVec[i];
				end
				if (phaseSel_q[REG_COUNT + i]) begin
					hrdata[7:0] = mask_q[i];
				end
			end
		end
	end

	always_comb begin
		irqOut = 1'b0;
		for (int i = 0; i < REG_COUNT; i++) begin
			irqOut = irqOut | (|(flagVec[i] & mask_q[i]));
		end
	end

endmodule : pif_irq_flags
`default_nettype wire

/* File: hw/pif_pkg.sv */
// constants for the peripheral interrupt flag registers
package pif_pkg;

	localparam int REG_COUNT = 3;
	localparam int REG_WIDTH = 8;
	localparam int ADDR_WIDTH = 14;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_FLAGS_CLOCK_ADC = 12'h070D;
	localparam logic [11:0] IDX_FLAGS_ANALOG = 12'h070E;
	localparam logic [11:0] IDX_FLAGS_SERIAL = 12'h070F;
	localparam logic [11:0] IDX_MASK_CLOCK_ADC = 12'h071D;
	localparam logic [11:0] IDX_MASK_ANALOG = 12'h071E;
	localparam logic [11:0] IDX_MASK_SERIAL = 12'h071F;

	// slot numbers in the register arrays
	localparam int SLOT_CLOCK_ADC = 0;
	localparam int SLOT_ANALOG = 1;
	localparam int SLOT_SERIAL = 2;

	// clock and adc register fields
	localparam int BIT_CLOCK_SWITCH = 6;
	localparam int BIT_ADC_THRESHOLD = 1;
	localparam int BIT_ADC_DONE = 0;
	// analog event register fields
	localparam int BIT_ZERO_CROSS = 6;
	localparam int BIT_CMP_TWO = 1;
	localparam int BIT_CMP_ONE = 0;
	// serial register fields
	localparam int BIT_SERIAL_RX = 5;
	localparam int BIT_SERIAL_TX = 4;
	localparam int BIT_BUS_COLL_TWO = 3;
	localparam int BIT_SYNC_TWO = 2;
	localparam int BIT_BUS_COLL_ONE = 1;
	localparam int BIT_SYNC_ONE = 0;

	// sticky, software-clearable bits of each register
	localparam logic [7:0] STICKY_CLOCK_ADC = 8'h43;
	localparam logic [7:0] STICKY_ANALOG = 8'h43;
	localparam logic [7:0] STICKY_SERIAL = 8'h0F;
	// read-only bits that follow a peripheral level
	localparam logic [7:0] LEVEL_SERIAL = 8'h30;

	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : pif_pkg

/* File: test/pif_checker.sv */
// port assertions for the interrupt flag registers
`timescale 1ns/1ps
`default_nettype none
module pif_checker
	import pif_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// peripherals
	input wire logic clockSwitchReady,
	input wire logic adcOpDone,
	input wire logic zeroCrossEvent,
	input wire logic [1:0] comparatorIrq,
	input wire logic [1:0] syncPortDone,
	input wire logic [1:0] busCollision,
	input wire logic serialRxNotEmpty,
	input wire logic serialTxHasRoom,
	input wire logic irqOut
);
	logic rdC, rdA, rdS;
	assign rdC = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_1C34;
	assign rdA = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_1C38;
	assign rdS = hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_1C3C;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bad response");
	chk_upper_zero: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper bits");
	chk_unmapped_read: assert property (hsel && hready && htrans[1] && !hwrite
		&& haddr[31:14] != 18'h0_0000 |=> hrdata == READ_ZERO) else $error("unmapped data");
	chk_level_copy: assert property (rdS |=> hrdata[5:4] ==
		$past({serialRxNotEmpty, serialTxHasRoom})) else $error("level flags");
	chk_clock_sets: assert property (rdC && clockSwitchReady |=> hrdata[6])
		else $error("clock flag");
	chk_adc_sets: assert property (rdC && adcOpDone |=> hrdata[1:0] == 2'b11)
		else $error("adc flags");
	chk_analog_sets: assert property (rdA |=> ({hrdata[6], hrdata[1:0]} &
		$past({zeroCrossEvent, comparatorIrq})) == $past({zeroCrossEvent, comparatorIrq}))
		else $error("analog flags");
	chk_serial_sets: assert property (rdS |=> (hrdata[3:0] & $past({busCollision[1],
		syncPortDone[1], busCollision[0], syncPortDone[0]})) == $past({busCollision[1],
		syncPortDone[1], busCollision[0], syncPortDone[0]})) else $error("serial flags");
	chk_set_wins: assert property (hsel && hready && htrans[1] && hwrite && haddr ==
		32'h0000_1C34 ##1 adcOpDone ##1 rdC |=> hrdata[1:0] == 2'b11) else $error("event lost");
	chk_reset_quiet: assert property ($fell(reset) |-> !irqOut) else $error("irq after reset");
endmodule : pif_checker
bind pif_irq_flags pif_checker u_pif_checker (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hresp, .clockSwitchReady, .adcOpDone, .zeroCrossEvent, .comparatorIrq,
	.syncPortDone, .busCollision, .serialRxNotEmpty, .serialTxHasRoom, .irqOut);
`default_nettype wire

/* File: test/pif_irq_flags_tb_top.sv */
// self-checking bench for the interrupt flag registers
`timescale 1ns/1ps
`default_nettype none
module pif_irq_flags_tb_top
	import pif_pkg::*;
;
	logic clk_sys, reset, hsel, hwrite, hready, hreadyout, hresp, irqOut;
	logic clockSwitchReady, adcOpDone, zeroCrossEvent, serialRxNotEmpty, serialTxHasRoom;
	logic [1:0] htrans, comparatorIrq, syncPortDone, busCollision;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, ra;
	logic [10:0] req;
	logic [7:0] rowExp [9] = '{8'h40, 8'h03, 8'h40, 8'h01, 8'h02, 8'h01, 8'h04, 8'h02, 8'h08};
	// every strobe pulsed for one cycle, in the same cycle as the address phase of the read
	logic [7:0] hitExp [3] = '{8'h43, 8'h43, 8'h0F};
	int errTotal = 0;
	int numChecks = 0;
	assign hready = hreadyout;
	pif_irq_flags u_pif_irq_flags (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .clockSwitchReady, .adcOpDone,
		.zeroCrossEvent, .comparatorIrq, .syncPortDone, .busCollision, .serialRxNotEmpty,
		.serialTxHasRoom, .irqOut);
	pif_periph_model u_pif_periph_model (.clk_sys, .req, .clockSwitchReady, .adcOpDone,
		.zeroCrossEvent, .comparatorIrq, .syncPortDone, .busCollision, .serialRxNotEmpty,
		.serialTxHasRoom);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rdChk(input logic [31:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, {24'h00_0000, e});
	endtask : rdChk
	task automatic results();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	initial begin
		#(25 * 3000);
		errTotal++;
		results();
	end
	initial begin
		{reset, hsel, haddr, htrans, hwrite, hsize, hwdata, req} = {1'b1, 36'h0, 3'b010, 43'h0};
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			ra = i < 2 ? 32'h0000_1C34 : i < 5 ? 32'h0000_1C38 : 32'h0000_1C3C;
			@(posedge clk_sys);
			req <= 11'(1 << i);
			@(posedge clk_sys);
			req <= 11'h000;
			repeat (3) @(posedge clk_sys);
			rdChk(ra, rowExp[i]);
			bus(1'b1, ra, 32'h0000_00FF);
			rdChk(ra, 8'h00);
			$display("row %0d done", i);
		end
		req <= 11'h600;
		repeat (2) @(posedge clk_sys);
		bus(1'b1, 32'h0000_1C3C, 32'h0000_00FF);
		rdChk(32'h0000_1C3C, 8'h30);
		req <= 11'h000;
		repeat (2) @(posedge clk_sys);
		rdChk(32'h0000_1C3C, 8'h00);
		$display("levels done");
		bus(1'b1, 32'h0000_1C74, 32'h0000_0003);
		rdChk(32'h0000_1C74, 8'h03);
		fork
			bus(1'b1, 32'h0000_1C34, 32'h0000_00FF);
			begin
				req <= 11'h002;
				@(posedge clk_sys);
				req <= 11'h000;
			end
		join
		rdChk(32'h0000_1C34, 8'h03);
		chk(32'(irqOut), 32'h0000_0001);
		bus(1'b1, 32'h0000_1C74, 32'h0000_0000);
		rdChk(32'h0001_1C34, 8'h00);
		chk(32'(irqOut), 32'h0000_0000);
		rdChk(32'h0000_1C34, 8'h03);
		$display("mask and collision done");
		for (int i = 0; i < 3; i++) begin
			req <= 11'h1FF;
			@(posedge clk_sys);
			req <= 11'h000;
			rdChk(32'h0000_1C34 + 32'(4 * i), hitExp[i]);
		end
		$display("strobe during read done");
		req <= 11'h1FF;
		@(posedge clk_sys);
		req <= 11'h000;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rdChk(32'h0000_1C34, 8'h00);
		rdChk(32'h0000_1C38, 8'h00);
		rdChk(32'h0000_1C3C, 8'h00);
		$display("reset done");
		results();
	end
endmodule : pif_irq_flags_tb_top
`default_nettype wire

/* File: test/pif_periph_model.sv */
// peripheral side: bench requests become strobes and buffer levels
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
	// clock and request
	input wire logic clk_sys,
	input wire logic [10:0] req,
	// peripheral outputs
	output logic clockSwitchReady,
	output logic adcOpDone,
	output logic zeroCrossEvent,
	output logic [1:0] comparatorIrq,
	output logic [1:0] syncPortDone,
	output logic [1:0] busCollision,
	output logic serialRxNotEmpty,
	output logic serialTxHasRoom
);
	logic [10:0] evt_q;
	always_ff @(posedge clk_sys) begin
		evt_q <= req;
	end
	assign {serialTxHasRoom, serialRxNotEmpty, busCollision, syncPortDone, comparatorIrq,
		zeroCrossEvent, adcOpDone, clockSwitchReady} = evt_q;
endmodule : pif_periph_model
`default_nettype wire
